/* hdl/aosb_pkg.sv */
// Constants, offsets and types shared by the oversampling buffer block
package aosb_pkg;
    // Sample, result, accumulator and bus widths
    localparam int ADC_W = 14;
    localparam int OS1_W = 15;
    localparam int OS2_W = 16;
    localparam int MA_SUM_W = 17;
    localparam int OS_ACC_W = 19;
    localparam int CH_ACC_W = 17;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Moving average buffer
    localparam int MA_LEN = 8;
    localparam int MA_AW = 3;
    localparam int MA_SHIFT = 3;
    // Register byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] RES14_OFS = 8'h08;
    localparam logic [7:0] RES15_OFS = 8'h0c;
    localparam logic [7:0] RES16_OFS = 8'h10;
    // Control fields and reset values
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_OS_BIT = 2;
    localparam logic [1:0] LEN2 = 2'h0;
    localparam logic [1:0] LEN4 = 2'h1;
    localparam logic [1:0] LEN8 = 2'h2;
    localparam logic [1:0] LEN16 = 2'h3;
    localparam logic [1:0] CTRL_LEN_RST = LEN4;
    localparam logic CTRL_OS_RST = 1'b1;
    // Status fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_F14_BIT = 1;
    localparam int STAT_F15_BIT = 2;
    localparam int STAT_F16_BIT = 3;
    // Start-up delay
    localparam int STARTUP_MS = 50;
    localparam int CLK_KHZ = 250000;
    localparam int STARTUP_CYCLES = STARTUP_MS * CLK_KHZ;
    // Start-up sequencing
    typedef enum logic {ST_WAIT, ST_RUN} aosb_state_t;
endpackage

/* hdl/aosb_ring.sv */
// Ring memory of the moving average buffer with registered oldest word
`timescale 1ns/1ps
module aosb_ring #(
    parameter int W = 14,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] oldest
);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] wptr_inc;
    logic [W-1:0] oldest_reg;

    assign wptr_inc = wptr_reg + {{(AW-1){1'b0}}, 1'b1};
    assign oldest = oldest_reg;

    // One storage word per entry, cleared at reset
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_word
        always_ff @(posedge clk)
        begin
            if (!nrst)
                mem_reg[i] <= '0;
            else if (wr_en && wptr_reg == AW'(i))
                mem_reg[i] <= wr_data;
        end
    end

    // Pointer and registered read of the word to be replaced next
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wptr_reg <= '0;
            oldest_reg <= '0;
        end
        else
        begin
            if (wr_en)
                wptr_reg <= wptr_inc;
            oldest_reg <= wr_en ? mem_reg[wptr_inc] : mem_reg[wptr_reg]; // Ready for back to back writes
        end
    end
endmodule

/* hdl/aosb_top.sv */
// Averaging and oversampling sample buffers with start-up gate and register port
// Functional notes
// [RULE1] Moving average buffer sums the last eight samples and divides by eight.
// [RULE2] Moving average result stays at 14 bits, no extra resolution.
// [RULE3] Oversampling mode can only be set with a length of 4 or 8.
// [RULE4] Four-word oversampling with decimation yields a 15-bit result.
// [RULE5] Four-word oversampling gives at most one result per four samples.
// [RULE6] Chained buffer takes each 15-bit result of the first as input.
// [RULE7] Chained buffer oversamples four results into a 16-bit result, 16x overall.
// [RULE8] Sampling starts only after a 50 ms start-up delay.
// [RULE9] 14, 15 and 16-bit results are each readable; host picks one.
// [RULE10] Decimation shifts the sum right by the number of gained bits.
// [RULE11] Four 14-bit values add into 16 bits, halved to 15 bits.
// [RULE12] The converter supplies samples at no more than 1 Msps.
// [RULE13] Oversampling result updates once per full group and holds until next.
// [RULE14] Moving average result refreshes on every new sample.
`timescale 1ns/1ps
module aosb_top #(
    parameter int STARTUP_CYC = aosb_pkg::STARTUP_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [aosb_pkg::ADC_W-1:0] ADC_DATA,
    input wire logic ADC_VALID,
    input wire logic [aosb_pkg::ADDR_W-1:0] ADDR,
    input wire logic [aosb_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [aosb_pkg::DATA_W-1:0] RDATA,
    output logic SAMPLE_EN
);
    import aosb_pkg::*;

    aosb_state_t state_reg;
    logic [31:0] dly_reg;
    logic [MA_SUM_W-1:0] ma_sum_reg;
    logic [ADC_W-1:0] res14_reg;
    logic [ADC_W-1:0] ma_oldest;
    logic [1:0] len_reg;
    logic os_reg;
    logic [OS_ACC_W-1:0] acc0_reg;
    logic [4:0] cnt0_reg;
    logic [OS1_W-1:0] res15_reg;
    logic b0_valid_reg;
    logic [CH_ACC_W-1:0] acc1_reg;
    logic [1:0] cnt1_reg;
    logic [OS2_W-1:0] res16_reg;
    logic f14_reg;
    logic f15_reg;
    logic f16_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic sample_en_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Start-up delay: conversions are refused until it has run out
    logic dly_done;
    logic sample_ok;
    assign dly_done = (dly_reg == 32'(STARTUP_CYC - 1));
    assign sample_ok = sample_en_reg && ADC_VALID; // RULE8

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            state_reg <= ST_WAIT;
            dly_reg <= '0;
            sample_en_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_WAIT:
                begin
                    dly_reg <= dly_reg + 32'h1;
                    if (dly_done)
                    begin
                        state_reg <= ST_RUN;
                        sample_en_reg <= 1'b1; // RULE8
                    end
                end
                default:
                    sample_en_reg <= 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Moving average buffer over the last eight samples
    logic [MA_SUM_W-1:0] ma_sum_next;
    assign ma_sum_next = ma_sum_reg + {3'h0, ADC_DATA} - {3'h0, ma_oldest}; // RULE1

    aosb_ring #(
        .W(ADC_W),
        .DEPTH(MA_LEN),
        .AW(MA_AW)
    ) u_ring (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(sample_ok),
        .wr_data(ADC_DATA),
        .oldest(ma_oldest)
    );

    // Running sum and divided result, refreshed on every sample
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            ma_sum_reg <= '0;
            res14_reg <= '0;
        end
        else if (sample_ok)
        begin
            ma_sum_reg <= ma_sum_next; // RULE14
            res14_reg <= ma_sum_next[MA_SUM_W-1:MA_SHIFT]; // RULE1 RULE2
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // First buffer: group average or oversampling with decimation
    logic [2:0] lg0;
    logic [2:0] sh0;
    logic [4:0] last0;
    logic done0;
    logic [OS_ACC_W-1:0] acc0_sum;
    logic [OS_ACC_W-1:0] acc0_scaled;
    logic ctrl_wr;
    logic [1:0] len_wr;
    logic os_allowed;
    assign lg0 = {1'b0, len_reg} + 3'h1;
    assign sh0 = lg0 - {2'h0, os_reg}; // RULE10
    assign last0 = 5'((6'h01 << lg0) - 6'h01);
    assign done0 = sample_ok && (cnt0_reg == last0);
    assign acc0_sum = acc0_reg + {5'h00, ADC_DATA}; // RULE11
    assign acc0_scaled = acc0_sum >> sh0; // RULE10
    assign ctrl_wr = WR && (ADDR == CTRL_OFS);
    assign len_wr = WDATA[CTRL_LEN_LSB +: 2];
    assign os_allowed = (len_wr == LEN4) || (len_wr == LEN8); // RULE3

    // Configuration; a new setting restarts the group
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            len_reg <= CTRL_LEN_RST;
            os_reg <= CTRL_OS_RST;
        end
        else if (ctrl_wr)
        begin
            len_reg <= len_wr;
            os_reg <= WDATA[CTRL_OS_BIT] && os_allowed; // RULE3
        end
    end

    // Accumulate a group, store and hold one result per group
    always_ff @(posedge CLK)
    begin
        if (!NRST || ctrl_wr)
        begin
            acc0_reg <= '0;
            cnt0_reg <= '0;
            b0_valid_reg <= 1'b0;
        end
        else
        begin
            b0_valid_reg <= done0; // RULE5
            if (done0)
            begin
                acc0_reg <= '0;
                cnt0_reg <= '0;
            end
            else if (sample_ok)
            begin
                acc0_reg <= acc0_sum;
                cnt0_reg <= cnt0_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
            res15_reg <= '0;
        else if (done0)
            res15_reg <= acc0_scaled[OS1_W-1:0]; // RULE4 RULE13
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chained buffer: four 15-bit results into one 16-bit result
    logic done1;
    logic [CH_ACC_W-1:0] acc1_sum;
    assign done1 = b0_valid_reg && (cnt1_reg == 2'h3);
    assign acc1_sum = acc1_reg + {2'h0, res15_reg}; // RULE6

    always_ff @(posedge CLK)
    begin
        if (!NRST || ctrl_wr)
        begin
            acc1_reg <= '0;
            cnt1_reg <= '0;
        end
        else if (b0_valid_reg)
        begin
            acc1_reg <= done1 ? '0 : acc1_sum; // RULE6
            cnt1_reg <= cnt1_reg + 2'h1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
            res16_reg <= '0;
        else if (done1)
            res16_reg <= acc1_sum[CH_ACC_W-1:1]; // RULE7
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port: fresh flags cleared by reading the result, a new result wins
    logic rd14;
    logic rd15;
    logic rd16;
    logic [DATA_W-1:0] rdata_next;
    assign rd14 = RD && (ADDR == RES14_OFS);
    assign rd15 = RD && (ADDR == RES15_OFS);
    assign rd16 = RD && (ADDR == RES16_OFS);

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            f14_reg <= 1'b0;
            f15_reg <= 1'b0;
            f16_reg <= 1'b0;
        end
        else
        begin
            f14_reg <= sample_ok || (f14_reg && !rd14);
            f15_reg <= done0 || (f15_reg && !rd15);
            f16_reg <= done1 || (f16_reg && !rd16);
        end
    end

    // Read selection; unmapped addresses read as zero
    always_comb
    begin
        rdata_next = '0;
        if (ADDR == CTRL_OFS)
            rdata_next = {29'h0, os_reg, len_reg};
        else if (ADDR == STAT_OFS)
            rdata_next = {28'h0, f16_reg, f15_reg, f14_reg, sample_en_reg};
        else if (ADDR == RES14_OFS)
            rdata_next = {18'h0, res14_reg}; // RULE9
        else if (ADDR == RES15_OFS)
            rdata_next = {17'h0, res15_reg}; // RULE9
        else if (ADDR == RES16_OFS)
            rdata_next = {16'h0, res16_reg}; // RULE9
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
            rdata_reg <= '0;
        else
            rdata_reg <= RD ? rdata_next : '0;
    end

    assign RDATA = rdata_reg;
    assign SAMPLE_EN = sample_en_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    startup_gate_a: assert property ($rose(sample_en_reg) |-> $past(dly_reg) == 32'(STARTUP_CYC - 1)) // RULE8
        else $error("sampling enabled before start-up delay");
    ma_average_a: assert property (sample_ok |=> res14_reg == ($past(ma_sum_next) >> MA_SHIFT)) // RULE1 RULE14
        else $error("moving average result wrong");
    ma_width_a: assert property (sample_ok |=> ma_sum_reg[MA_SUM_W-1:MA_SHIFT] == res14_reg) // RULE2
        else $error("moving average gained resolution");
    os_gate_a: assert property (os_reg |-> (len_reg == LEN4 || len_reg == LEN8)) // RULE3
        else $error("oversampling set with illegal length");
    os4_result_a: assert property (done0 && os_reg && len_reg == LEN4 |=> res15_reg == $past(acc0_sum[15:1])) // RULE4 RULE11
        else $error("four-word oversampled result wrong");
    os_rate_a: assert property (b0_valid_reg && os_reg |-> $past(cnt0_reg) >= 5'h03) // RULE5
        else $error("oversampled result faster than quarter rate");
    os_hold_a: assert property (!done0 |=> $stable(res15_reg)) // RULE13
        else $error("oversampled result changed mid-group");
    chain_in_a: assert property (b0_valid_reg && !ctrl_wr && cnt1_reg == 2'h0 |=> acc1_reg == {2'h0, $past(res15_reg)}) // RULE6
        else $error("chained buffer missed first result");
    chain_16_a: assert property (done1 |=> res16_reg == $past(acc1_sum[16:1])) // RULE7
        else $error("chained result wrong");
    read_res16_a: assert property (rd16 |=> RDATA == {16'h0, $past(res16_reg)}) // RULE9
        else $error("16-bit result read wrong");

    cover_len8_c: cover property (done0 && len_reg == LEN8 && os_reg);
    cover_chain_c: cover property (done1);
    cover_os_reject_c: cover property (ctrl_wr && WDATA[CTRL_OS_BIT] && !os_allowed);
    cover_read14_c: cover property (rd14 && f14_reg);
endmodule

/* testbench/aosb_adc_model.sv */
// Behavioural model of the sampling converter that feeds the buffers
`timescale 1ns/1ps
module aosb_adc_model #(
    parameter int GAP = 250
) (
    input wire logic clk,
    output logic [13:0] adc_data,
    output logic adc_valid
);
    // Idle state at time zero
    initial
    begin
        adc_data = 14'h0000;
        adc_valid = 1'b0;
    end

    // One-cycle strobe, then GAP - 1 cycles of quiet, one strobe per GAP cycles, so the rate stays at or below 1 Msps
    task automatic send(input logic [13:0] v);
        @(posedge clk);
        adc_data <= v;
        adc_valid <= 1'b1;
        @(posedge clk);
        adc_valid <= 1'b0;
        adc_data <= ~v; // Stale data must not look valid
        repeat (GAP - 2) @(posedge clk);
    endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench of the oversampling buffer block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import aosb_pkg::*;
    localparam int SU = 20;
    logic clk, nrst, wr, rd, adc_valid, sample_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d, e14, e15, e16;
    logic [ADC_W-1:0] adc_data;
    logic [ADC_W-1:0] hist [0:7];
    logic f15, f16;
    int bad_count, checked, cyc, g, acc, cg, cacc, m_len, m_os;

    ////////////////////////////////////////////////////////////////
    // Design and converter
    aosb_top #(.STARTUP_CYC(SU)) u_dut (.CLK(clk), .NRST(nrst), .ADC_DATA(adc_data), .ADC_VALID(adc_valid),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SAMPLE_EN(sample_en));
    aosb_adc_model #(.GAP(250)) u_adc (.clk(clk), .adc_data(adc_data), .adc_valid(adc_valid));

    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register port cycles
    task automatic wr_t(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_t(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Configure, mirror the control word and check what is kept
    task automatic cfg(input int len, input int os);
        wr_t(CTRL_OFS, 32'(os * 4 + len));
        m_len = len;
        m_os = (os != 0 && (len == 1 || len == 2)) ? 1 : 0;
        g = 0;
        acc = 0;
        cg = 0;
        cacc = 0;
        rd_t(CTRL_OFS);
        `CHK(d, 32'(m_os * 4 + m_len))
    endtask

    // Send one sample, advance the reference and check all results
    task automatic smp(input int v);
        int s;
        u_adc.send(v[ADC_W-1:0]);
        for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = v[ADC_W-1:0];
        s = 0;
        foreach (hist[i]) s += hist[i];
        e14 = 32'(s >> 3);
        acc += v;
        g++;
        f15 = 1'b0;
        f16 = 1'b0;
        if (g == (2 << m_len))
        begin
            e15 = 32'(acc >> (m_len + 1 - m_os));
            f15 = 1'b1;
            cacc += e15;
            cg++;
            acc = 0;
            g = 0;
            if (cg == 4)
            begin
                e16 = 32'(cacc >> 1);
                f16 = 1'b1;
                cacc = 0;
                cg = 0;
            end
        end
        rd_t(STAT_OFS);
        `CHK(d, {28'h0, f16, f15, 2'h3})
        rd_t(RES14_OFS);
        `CHK(d, e14)
        rd_t(RES15_OFS);
        `CHK(d, e15)
        rd_t(RES16_OFS);
        `CHK(d, e16)
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_startup;
        @(posedge clk);
        #1 `CHK(sample_en, 1'b0)
        u_adc.send(14'h1abc);
        #1 `CHK(sample_en, 1'b1)
        rd_t(STAT_OFS);
        `CHK(d, 32'h1)
        rd_t(RES14_OFS);
        `CHK(d, 32'h0)
        rd_t(CTRL_OFS);
        `CHK(d, {29'h0, CTRL_OS_RST, CTRL_LEN_RST})
        rd_t(8'h14);
        `CHK(d, 32'h0)
        rd_t(CTRL_OFS);
        @(posedge clk);
        #1 `CHK(rdata, 32'h0)
    endtask
    task automatic t_chain;
        for (int k = 0; k < 16; k++) smp(16383 - k * 3);
    endtask
    task automatic t_ctrl;
        for (int c = 0; c < 4; c++) cfg(c, 1);
        cfg(2, 1);
        for (int k = 0; k < 8; k++) smp(k * 1000 + 77);
        cfg(1, 0);
        for (int k = 0; k < 4; k++) smp(16383 - k * 5000);
        // Two-word and sixteen-word plain group averages
        cfg(0, 0);
        for (int k = 0; k < 2; k++) smp(12345 + k);
        cfg(3, 0);
        for (int k = 0; k < 16; k++) smp(k * 1000 + 3);
    endtask

    // Verdict
    task automatic finish_test;
        $display("checks=%0d errors=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        bad_count = 0;
        checked = 0;
        cyc = 0;
        foreach (hist[i]) hist[i] = 14'h0000;
        {g, acc, cg, cacc, m_len, m_os} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1, 32'd1};
        {e14, e15, e16} = {32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_startup();
        t_chain();
        t_ctrl();
        finish_test();
    end
endmodule
